// File: include/cfc_pkg.sv
// Purpose: shared constants and types of the condition flag compare unit
// Assumes: 32-bit data and pointer registers, 40-bit accumulators
// Notes: register offsets are byte addresses on the APB side
package cfc_pkg;

    localparam int DATA_W = 32;
    localparam int ACC_W = 40;
    localparam int EXT_W = 41;
    localparam int NUM_REGS = 8;
    localparam int INSN_W = 16;
    localparam int IMM_W = 3;
    localparam int APB_AW = 12;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [11:0] OFS_ARITH_STATUS = 12'h000;
    localparam logic [11:0] OFS_LAST_INSN = 12'h004;
    localparam logic [11:0] OFS_ISSUE_ERR = 12'h008;
    localparam logic [11:0] OFS_CMP_COUNT = 12'h00C;

    localparam int BIT_ZERO = 0;
    localparam int BIT_NEG = 1;
    localparam int BIT_CARRY = 2;
    localparam int BIT_COND = 5;
    localparam logic RST_FLAG = 1'h0;
    localparam logic [15:0] RST_INSN = 16'h0000;
    localparam logic [31:0] RST_COUNT = 32'h0000_0000;

    // ----------------------------------------
    // instruction word fields
    // ----------------------------------------
    localparam int FLD_CLASS_HI = 15;
    localparam int FLD_CLASS_LO = 12;
    localparam logic [3:0] CLASS_CMP = 4'hC;
    localparam int FLD_KIND_HI = 11;
    localparam int FLD_KIND_LO = 10;
    localparam int FLD_TEST_HI = 9;
    localparam int FLD_TEST_LO = 8;
    localparam int FLD_UNSIGNED = 7;
    localparam int FLD_USE_IMM = 6;
    localparam int FLD_SRC_A_HI = 5;
    localparam int FLD_SRC_A_LO = 3;
    localparam int FLD_SRC_B_HI = 2;
    localparam int FLD_SRC_B_LO = 0;

    typedef enum logic [1:0] {KIND_DATA, KIND_PTR, KIND_ACC, KIND_RSVD} cfc_kind_e;
    typedef enum logic [1:0] {TEST_EQ, TEST_LT, TEST_LE, TEST_RSVD} cfc_test_e;

    typedef struct packed {
        logic condition_flag;
        logic carry_flag;
        logic negative_flag;
        logic zero_flag;
    } cfc_flags_s;

    typedef struct packed {
        logic [NUM_REGS-1:0][DATA_W-1:0] dreg;
        logic [NUM_REGS-1:0][DATA_W-1:0] preg;
        logic [ACC_W-1:0] accumulator_first;
        logic [ACC_W-1:0] accumulator_second;
    } cfc_regfile_s;

    typedef struct packed {
        logic valid;
        logic parallel;
        logic [INSN_W-1:0] insn;
    } cfc_issue_s;

endpackage : cfc_pkg

// File: core/cfc_compare_unit.sv
// Purpose: condition flag compare datapath with APB view of its status
// Assumes: decoder and register files share i_mclk; operands stable on issue
// Notes: one issue per cycle; results visible one edge after issue
//
// Summary of operation
// - condition flag is one bit inside the arithmetic status register
// - data compares take two of eight data registers, or register and immediate
// - data and pointer compares are 32-bit signed, unsigned under the option
// - compare subtracts second from first; difference dropped, only flags written
// - condition flag set when the test holds, cleared otherwise
// - signed tests: equal by zero, less by negative, less-equal by either
// - unsigned: less when carry clear, less-equal adds zero; no unsigned equal
// - data compares also write zero, negative and carry flags
// - signed immediate is three bits, minus four to plus three
// - unsigned immediate is three bits, zero to seven, unsigned option only
// - pointer compares accept six pointers, stack pointer and frame pointer
// - pointer compares change only the condition flag
// - accumulator compares are 40-bit signed
// - accumulator compares have no unsigned and no immediate forms
// - accumulator tests: equal by zero, less by negative, less-equal by either
// - accumulator compares also write zero, negative and carry flags
// - status flags not named by a form keep their values
// - branch decisions use only the current condition flag
// - each compare form is one 16-bit instruction word
// - compares are refused when issued in parallel with other instructions
`timescale 1ns/1ns
module cfc_compare_unit
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire cfc_pkg::cfc_issue_s i_issue,
    input wire cfc_pkg::cfc_regfile_s i_regs,
    input wire logic i_branch_req,
    input wire logic i_branch_sense,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [cfc_pkg::APB_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output cfc_pkg::cfc_flags_s o_flags,
    output logic o_cmp_done,
    output logic o_refused,
    output logic o_branch_taken
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // widen a small immediate to the subtract width
    function automatic logic [cfc_pkg::EXT_W-1:0] widen_imm
    (
        input logic [cfc_pkg::IMM_W-1:0] imm,
        input logic is_unsigned
    );
        logic [cfc_pkg::EXT_W-1:0] r;
        if (is_unsigned)
        begin
            r = {{(cfc_pkg::EXT_W-cfc_pkg::IMM_W){1'b0}}, imm};
        end
        else
        begin
            r = {{(cfc_pkg::EXT_W-cfc_pkg::IMM_W){imm[2]}}, imm};
        end
        return r;
    endfunction : widen_imm

    // widen a 32-bit register operand, signed or not
    function automatic logic [cfc_pkg::EXT_W-1:0] widen_reg
    (
        input logic [cfc_pkg::DATA_W-1:0] v,
        input logic is_unsigned
    );
        logic s;
        s = v[cfc_pkg::DATA_W-1] & ~is_unsigned;
        return {{(cfc_pkg::EXT_W-cfc_pkg::DATA_W){s}}, v};
    endfunction : widen_reg

    function automatic logic [31:0] status_word(input cfc_pkg::cfc_flags_s f);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[cfc_pkg::BIT_ZERO] = f.zero_flag;
        w[cfc_pkg::BIT_NEG] = f.negative_flag;
        w[cfc_pkg::BIT_CARRY] = f.carry_flag;
        w[cfc_pkg::BIT_COND] = f.condition_flag;
        return w;
    endfunction : status_word

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic [cfc_pkg::INSN_W-1:0] insn;
    cfc_pkg::cfc_kind_e kind;
    cfc_pkg::cfc_test_e test;
    logic opt_unsigned;
    logic use_imm;
    logic [2:0] src_a;
    logic [2:0] src_b;
    logic legal;
    logic accept;
    logic refuse;

    assign insn = i_issue.insn;
    assign kind = cfc_pkg::cfc_kind_e'(insn[cfc_pkg::FLD_KIND_HI:cfc_pkg::FLD_KIND_LO]);
    assign test = cfc_pkg::cfc_test_e'(insn[cfc_pkg::FLD_TEST_HI:cfc_pkg::FLD_TEST_LO]);
    assign opt_unsigned = insn[cfc_pkg::FLD_UNSIGNED];
    assign use_imm = insn[cfc_pkg::FLD_USE_IMM];
    assign src_a = insn[cfc_pkg::FLD_SRC_A_HI:cfc_pkg::FLD_SRC_A_LO];
    assign src_b = insn[cfc_pkg::FLD_SRC_B_HI:cfc_pkg::FLD_SRC_B_LO];

    always_comb
    begin
        legal = (insn[cfc_pkg::FLD_CLASS_HI:cfc_pkg::FLD_CLASS_LO]
                 == cfc_pkg::CLASS_CMP);
        if (kind == cfc_pkg::KIND_RSVD || test == cfc_pkg::TEST_RSVD)
        begin
            legal = 1'b0;
        end
        if (opt_unsigned && test == cfc_pkg::TEST_EQ)
        begin
            legal = 1'b0;
        end
        if (kind == cfc_pkg::KIND_ACC && (opt_unsigned || use_imm))
        begin
            legal = 1'b0;
        end
    end

    // privilege level is not consulted at all, so no fault path exists
    assign accept = i_issue.valid & legal & ~i_issue.parallel;
    assign refuse = i_issue.valid & ~accept;

    // ----------------------------------------
    // operand select and subtract
    // ----------------------------------------
    logic [cfc_pkg::EXT_W-1:0] op_a;
    logic [cfc_pkg::EXT_W-1:0] op_b;
    logic [cfc_pkg::EXT_W-1:0] diff;
    logic [cfc_pkg::DATA_W:0] sub32;
    logic [cfc_pkg::ACC_W:0] sub40;
    logic res_zero;
    logic res_neg;
    logic res_carry;
    logic res_cond;

    always_comb
    begin
        op_a = '0;
        op_b = '0;
        case (kind)
            cfc_pkg::KIND_DATA:
            begin
                op_a = widen_reg(i_regs.dreg[src_a], opt_unsigned);
                op_b = use_imm ? widen_imm(src_b, opt_unsigned)
                               : widen_reg(i_regs.dreg[src_b], opt_unsigned);
            end
            cfc_pkg::KIND_PTR:
            begin
                // entries 6 and 7 are stack_pointer and frame_pointer
                op_a = widen_reg(i_regs.preg[src_a], opt_unsigned);
                op_b = use_imm ? widen_imm(src_b, opt_unsigned)
                               : widen_reg(i_regs.preg[src_b], opt_unsigned);
            end
            cfc_pkg::KIND_ACC:
            begin
                op_a = {i_regs.accumulator_first[cfc_pkg::ACC_W-1],
                        i_regs.accumulator_first};
                op_b = {i_regs.accumulator_second[cfc_pkg::ACC_W-1],
                        i_regs.accumulator_second};
            end
            default:
            begin
                op_a = '0;
                op_b = '0;
            end
        endcase
    end

    // difference is only looked at, never stored
    assign diff = op_a - op_b;
    assign sub32 = {1'b0, op_a[cfc_pkg::DATA_W-1:0]} + {1'b0, ~op_b[cfc_pkg::DATA_W-1:0]}
                   + {{cfc_pkg::DATA_W{1'b0}}, 1'b1};
    assign sub40 = {1'b0, op_a[cfc_pkg::ACC_W-1:0]} + {1'b0, ~op_b[cfc_pkg::ACC_W-1:0]}
                   + {{cfc_pkg::ACC_W{1'b0}}, 1'b1};

    always_comb
    begin
        if (kind == cfc_pkg::KIND_ACC)
        begin
            res_zero = (diff[cfc_pkg::ACC_W-1:0] == '0);
            res_neg = diff[cfc_pkg::EXT_W-1];
            res_carry = sub40[cfc_pkg::ACC_W];
        end
        else
        begin
            res_zero = (diff[cfc_pkg::DATA_W-1:0] == '0);
            // exact sign keeps signed less-than right across overflow
            res_neg = opt_unsigned ? diff[cfc_pkg::DATA_W-1] : diff[cfc_pkg::EXT_W-1];
            res_carry = sub32[cfc_pkg::DATA_W];
        end
        case (test)
            cfc_pkg::TEST_EQ: res_cond = res_zero;
            cfc_pkg::TEST_LT: res_cond = opt_unsigned ? ~res_carry : res_neg;
            cfc_pkg::TEST_LE: res_cond = opt_unsigned ? (~res_carry | res_zero)
                                                      : (res_neg | res_zero);
            default: res_cond = 1'b0;
        endcase
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    logic apb_done;
    logic wr_status;
    logic wr_err;
    logic addr_ok;

    assign apb_done = i_psel & i_penable & o_pready;
    assign addr_ok = (i_paddr == cfc_pkg::OFS_ARITH_STATUS) || (i_paddr == cfc_pkg::OFS_LAST_INSN)
                     || (i_paddr == cfc_pkg::OFS_ISSUE_ERR) || (i_paddr == cfc_pkg::OFS_CMP_COUNT);
    assign wr_status = apb_done & i_pwrite & (i_paddr == cfc_pkg::OFS_ARITH_STATUS);
    assign wr_err = apb_done & i_pwrite & (i_paddr == cfc_pkg::OFS_ISSUE_ERR);

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready <= i_psel & i_penable & ~o_pready;
            o_pslverr <= i_psel & i_penable & ~o_pready & ~addr_ok;
        end
    end

    logic [cfc_pkg::INSN_W-1:0] last_insn;
    logic issue_err;
    logic [31:0] cmp_count;

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_prdata <= 32'h0000_0000;
        end
        else if (i_psel & i_penable & ~o_pready & ~i_pwrite)
        begin
            case (i_paddr)
                cfc_pkg::OFS_ARITH_STATUS: o_prdata <= status_word(o_flags);
                cfc_pkg::OFS_LAST_INSN: o_prdata <= {16'h0000, last_insn};
                cfc_pkg::OFS_ISSUE_ERR: o_prdata <= {31'h0, issue_err};
                cfc_pkg::OFS_CMP_COUNT: o_prdata <= cmp_count;
                default: o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // flags
    // ----------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_flags <= '{default: cfc_pkg::RST_FLAG};
        end
        else if (accept)
        begin
            o_flags.condition_flag <= res_cond;
            // pointer compares leave the other flags alone
            if (kind != cfc_pkg::KIND_PTR)
            begin
                o_flags.zero_flag <= res_zero;
                o_flags.negative_flag <= res_neg;
                o_flags.carry_flag <= res_carry;
            end
        end
        else if (wr_status)
        begin
            // a compare in the same cycle wins over software
            o_flags.zero_flag <= i_pwdata[cfc_pkg::BIT_ZERO];
            o_flags.negative_flag <= i_pwdata[cfc_pkg::BIT_NEG];
            o_flags.carry_flag <= i_pwdata[cfc_pkg::BIT_CARRY];
            o_flags.condition_flag <= i_pwdata[cfc_pkg::BIT_COND];
        end
    end

    // ----------------------------------------
    // issue bookkeeping
    // ----------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_cmp_done <= 1'b0;
            o_refused <= 1'b0;
            last_insn <= cfc_pkg::RST_INSN;
            cmp_count <= cfc_pkg::RST_COUNT;
        end
        else
        begin
            o_cmp_done <= accept;
            o_refused <= refuse;
            if (accept)
            begin
                last_insn <= insn;
                cmp_count <= cmp_count + 32'h0000_0001;
            end
        end
    end

    // sticky refusal flag, write one to clear; a new refusal beats the clear
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            issue_err <= cfc_pkg::RST_FLAG;
        end
        else if (refuse)
        begin
            issue_err <= 1'b1;
        end
        else if (wr_err && i_pwdata[0])
        begin
            issue_err <= 1'b0;
        end
    end

    // ----------------------------------------
    // branch decision
    // ----------------------------------------
    // uses the registered flag only; a compare in the same cycle is seen next cycle
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_branch_taken <= 1'b0;
        end
        else
        begin
            o_branch_taken <= i_branch_req
                              & (o_flags.condition_flag == i_branch_sense);
        end
    end

endmodule : cfc_compare_unit

// File: bench/cfc_compare_unit_props.sv
// Purpose: port relations of the compare unit
// Assumes: one clock, async active-low reset
// Notes: bound into every instance of the unit
`timescale 1ns/1ns
module cfc_compare_unit_props
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire cfc_pkg::cfc_issue_s i_issue,
    input wire logic i_branch_req,
    input wire logic i_branch_sense,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic o_pready,
    input wire cfc_pkg::cfc_flags_s o_flags,
    input wire logic o_cmp_done,
    input wire logic o_refused,
    input wire logic o_branch_taken
);
    wire logic [15:0] w = i_issue.insn;
    wire logic un = w[7];
    wire logic par = i_issue.valid && i_issue.parallel;
    wire logic ok = i_issue.valid && !i_issue.parallel && w[15:12] == 4'hC && w[11:10] != 2'h3
        && w[9:8] != 2'h3 && !(un && w[9:8] == 2'h0) && !(w[11:10] == 2'h2 && (un || w[6]));
    wire logic sgn = ok && !un && w[11:10] != 2'h1;
    // a status write landing beside a refusal may move the flags legally
    wire logic apb_wr = i_psel && i_penable && i_pwrite && o_pready;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_done_pulse:
        assert property (ok |=> o_cmp_done && !o_refused)
        else $error("legal compare gave no done pulse");
    chk_par_refused:
        assert property (par |=> o_refused && !o_cmp_done)
        else $error("parallel issue not refused");
    chk_refuse_hold:
        assert property (i_issue.valid && !ok && !apb_wr |=> $stable(o_flags))
        else $error("refused issue moved the flags");
    chk_ptr_status:
        assert property (ok && w[11:10] == 2'h1 |=> o_flags[2:0] == $past(o_flags[2:0]))
        else $error("pointer compare moved status flags");
    chk_eq_zero:
        assert property (sgn && w[9:8] == 2'h0 |=> o_flags.condition_flag == o_flags.zero_flag)
        else $error("equal test not judged by zero");
    chk_lt_neg:
        assert property (sgn && w[9:8] == 2'h1 |=> o_flags.condition_flag == o_flags.negative_flag)
        else $error("signed less not judged by negative");
    chk_le_signed:
        assert property (sgn && w[9:8] == 2'h2 |=>
            o_flags.condition_flag == (o_flags.negative_flag || o_flags.zero_flag))
        else $error("signed less-equal wrong");
    chk_lt_carry:
        assert property (ok && un && w[11:10] == 2'h0 && w[9:8] == 2'h1 |=>
            o_flags.condition_flag == !o_flags.carry_flag)
        else $error("unsigned less not judged by carry");
    chk_branch_sense:
        assert property (i_branch_req |=>
            o_branch_taken == ($past(o_flags.condition_flag) == $past(i_branch_sense)))
        else $error("branch decision wrong");
    chk_branch_idle:
        assert property (!i_branch_req |=> !o_branch_taken)
        else $error("branch taken without request");
    chk_apb_wait:
        assert property (i_psel && !i_penable |=> !o_pready ##1 o_pready)
        else $error("apb wait state wrong");
    cover property (ok && w[11:10] == 2'h2);
    cover property (par);
    cover property (i_branch_req ##1 o_branch_taken);
endmodule : cfc_compare_unit_props

bind cfc_compare_unit cfc_compare_unit_props i_props
(
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_issue(i_issue), .i_branch_req(i_branch_req),
    .i_branch_sense(i_branch_sense), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .o_pready(o_pready), .o_flags(o_flags), .o_cmp_done(o_cmp_done),
    .o_refused(o_refused), .o_branch_taken(o_branch_taken)
);

// File: bench/cfc_regfile_model.sv
// Purpose: register files that feed the compare unit
// Assumes: bench hands a full snapshot one edge ahead of an issue
// Notes: registered so operands never move at the issue edge
`timescale 1ns/1ns
module cfc_regfile_model
(
    input wire logic i_mclk,
    input wire cfc_pkg::cfc_regfile_s i_value,
    output cfc_pkg::cfc_regfile_s o_regs
);
    // compares never write back, so nothing here listens to the unit
    always_ff @(posedge i_mclk)
    begin
        o_regs <= i_value;
    end
endmodule : cfc_regfile_model

// File: bench/cfc_compare_unit_tb.sv
// Purpose: self-checking bench of the compare unit
// Assumes: inputs driven just after the rising edge
// Notes: random compares checked against an integer flag model
`timescale 1ns/1ns
module cfc_compare_unit_tb;
    logic i_mclk;
    logic i_rst_b;
    cfc_pkg::cfc_issue_s iss;
    cfc_pkg::cfc_regfile_s rf, nv, regs;
    cfc_pkg::cfc_flags_s flags;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic breq, bsense, psel, penable, pwrite, pready, pslverr, done, refused, taken, err;
    logic [15:0] word, lastw;
    int bad_count, samples_checked, cycles, ez, en, ec, ecc;
    int nacc, anyref;

    cfc_regfile_model i_rfm (.i_mclk(i_mclk), .i_value(rf), .o_regs(regs));
    cfc_compare_unit i_dut
    (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_issue(iss), .i_regs(regs),
        .i_branch_req(breq), .i_branch_sense(bsense), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_flags(flags), .o_cmp_done(done),
        .o_refused(refused), .o_branch_taken(taken)
    );

    initial
    begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    // tests need about 2000 cycles
    always @(posedge i_mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count++;
            test_done();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    task automatic test_done();
        $display("checked %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        penable <= 1'b1;
        // pready ends this wait; the bench timeout ends one that never sees it
        do
        begin
            @(posedge i_mclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic branch(input logic s);
        @(posedge i_mclk);
        breq <= 1'b1;
        bsense <= s;
        @(posedge i_mclk);
        breq <= 1'b0;
        #1;
        chk(taken, ecc == s);
    endtask : branch

    task automatic issue(input logic [15:0] w, input logic par);
        logic ok;
        logic [31:0] va, vb;
        longint sa, sb, ua, ub;
        int t, u, z, n, c;
        // operands are read after this edge, once the new snapshot has landed in rf
        @(posedge i_mclk);
        iss <= '{valid: 1'b1, parallel: par, insn: w};
        t = w[9:8];
        u = w[7];
        ok = w[15:12] == 4'hC && w[11:10] != 2'h3 && t != 3 && !par && !(u && t == 0)
            && !(w[11:10] == 2'h2 && (u || w[6]));
        va = (w[11:10] == 2'h0) ? rf.dreg[w[5:3]] : rf.preg[w[5:3]];
        vb = (w[11:10] == 2'h0) ? rf.dreg[w[2:0]] : rf.preg[w[2:0]];
        if (w[6])
        begin
            vb = u ? {29'h0, w[2:0]} : {{29{w[2]}}, w[2:0]};
        end
        sa = longint'($signed(va));
        sb = longint'($signed(vb));
        ua = longint'(va);
        ub = longint'(vb);
        if (w[11:10] == 2'h2)
        begin
            sa = longint'($signed(rf.accumulator_first));
            sb = longint'($signed(rf.accumulator_second));
            ua = longint'(rf.accumulator_first);
            ub = longint'(rf.accumulator_second);
        end
        z = int'(ua == ub);
        c = int'(ua >= ub);
        n = u ? int'((ua - ub) >> 31) & 1 : int'(sa < sb);
        @(posedge i_mclk);
        iss.valid <= 1'b0;
        if (ok)
        begin
            nacc++;
            lastw = w;
            ecc = (t == 0) ? z : (t == 1) ? (u ? !c : n) : (u ? (!c || z) : (n || z));
            if (w[11:10] != 2'h1)
            begin
                ez = z;
                en = n;
                ec = c;
            end
        end
        else
        begin
            anyref = 1;
        end
        #1;
        chk({done, refused}, {ok, !ok});
        chk(flags, {ecc[0], ec[0], en[0], ez[0]});
    endtask : issue
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        i_rst_b = 1'b0;
        iss = '0;
        rf = '0;
        {breq, bsense, psel, penable, pwrite} = '0;
        paddr = '0;
        pwdata = '0;
        {bad_count, samples_checked, cycles, ez, en, ec, ecc} = '0;
        nacc = 0;
        anyref = 0;
        lastw = '0;
        void'($urandom(6));
        repeat (10) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h000, 32'h0000_0023);
        ecc = 1;
        en = 1;
        ez = 1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_0023);
        branch(1'b1);
        branch(1'b0);
        apb(1'b0, 12'hFF0, 32'h0);
        chk({err, rd}, 33'h1_0000_0000);
        $display("register test done");
        repeat (400)
        begin
            for (int i = 0; i < 8; i++)
            begin
                nv.dreg[i] = ($urandom % 2) ? $urandom : 32'($urandom % 8) - 32'h4;
                nv.preg[i] = ($urandom % 2) ? $urandom : 32'($urandom % 8) - 32'h4;
            end
            nv.accumulator_first = 40'({$urandom, $urandom});
            nv.accumulator_second = ($urandom % 2) ? nv.accumulator_first
                                                   : 40'({$urandom, $urandom});
            @(posedge i_mclk);
            rf <= nv;
            word = {(($urandom % 16) == 0) ? 4'($urandom) : 4'hC, 12'($urandom)};
            issue(word, ($urandom % 8) == 0);
            branch(1'($urandom));
        end
        $display("compare test done");
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, nacc);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, lastw);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, anyref);
        apb(1'b1, 12'h008, 32'h0000_0001);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0);
        $display("bookkeeping test done");
        test_done();
    end
endmodule : cfc_compare_unit_tb
